// File: hw/flash_seq_pkg.sv
/*
 package for the program/erase sequencer: opcodes, operation kinds,
 carrier structs, region masks and timing constants.
 assumes a 250 MHz system clock; no bus, all status bits are ports.
*/
package flash_seq_pkg;
   // command opcodes
   localparam logic [7:0] OPC_WRITE_EN  = 8'h06;
   localparam logic [7:0] OPC_WRITE_DIS = 8'h04;
   localparam logic [7:0] OPC_PROG      = 8'h02;
   localparam logic [7:0] OPC_QUAD_PROG = 8'h32;
   localparam logic [7:0] OPC_SECTOR    = 8'h20;
   localparam logic [7:0] OPC_BLOCK32   = 8'h52;
   localparam logic [7:0] OPC_BLOCK64   = 8'hd8;
   localparam logic [7:0] OPC_CHIP_A    = 8'hc7;
   localparam logic [7:0] OPC_CHIP_B    = 8'h60;
   localparam logic [7:0] OPC_SUSPEND   = 8'h75;
   localparam logic [7:0] OPC_RESUME    = 8'h7a;

   // frame geometry
   localparam int          OPCODE_BITS = 8;
   localparam logic [15:0] ADDR_BITS   = 16'h0018;
   localparam logic [15:0] MIN_PROG    = 16'h0020;
   localparam logic [15:0] BITS_SAT    = 16'hfff0;
   localparam int          PAGE_BYTES  = 256;

   // region masks, the bits ignored when comparing two targets
   localparam logic [23:0] PAGE_MASK    = 24'h0000ff;
   localparam logic [23:0] SECTOR_MASK  = 24'h000fff;
   localparam logic [23:0] BLOCK32_MASK = 24'h007fff;
   localparam logic [23:0] BLOCK64_MASK = 24'h00ffff;
   localparam logic [23:0] CHIP_MASK    = 24'hffffff;

   // timing
   localparam int    CLOCK_PERIOD_NS      = 4;
   localparam int    RESUME_BUSY_MAX_NS   = 200;
   localparam int    RESUME_BUSY_CYCLES   = RESUME_BUSY_MAX_NS / CLOCK_PERIOD_NS;
   localparam int    TIMER_W              = 40;
   localparam longint PROGRAM_TIME_US     = 400;
   localparam longint SECTOR_TIME_US      = 45000;
   localparam longint BLOCK32_TIME_US     = 120000;
   localparam longint BLOCK64_TIME_US     = 150000;
   localparam longint CHIP_TIME_US        = 2000000;
   localparam longint SUSPEND_LATENCY_US  = 20;
   localparam longint PROGRAM_CYCLES_DEF  = PROGRAM_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam longint SECTOR_CYCLES_DEF   = SECTOR_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam longint BLOCK32_CYCLES_DEF  = BLOCK32_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam longint BLOCK64_CYCLES_DEF  = BLOCK64_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam longint CHIP_CYCLES_DEF     = CHIP_TIME_US * 1000 / CLOCK_PERIOD_NS;
   localparam longint SUSPEND_CYCLES_DEF  = SUSPEND_LATENCY_US * 1000 / CLOCK_PERIOD_NS;

   // reset value of the synchronised pins {lanes, chip select, link clock}
   localparam logic [5:0] PIN_RESET = 6'h02;

   typedef enum logic [2:0] {
      K_NONE    = 3'h0,
      K_PROG    = 3'h1,
      K_SECTOR  = 3'h2,
      K_BLOCK32 = 3'h3,
      K_BLOCK64 = 3'h4,
      K_CHIP    = 3'h5
   } op_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RUN    = 3'b001,
      ST_FLUSH  = 3'b011,
      ST_HALT   = 3'b010,
      ST_RESUME = 3'b110
   } seq_state_t;

   typedef struct packed {
      op_kind_t    kind;
      logic [23:0] addr;
   } op_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0]  data;
   } mem_write_t;
endpackage

// File: hw/bit_sync.sv
/*
 two-flop synchroniser, one chain per bit.
 assumes inputs are asynchronous to i_clock and quasi-static per bit.
*/
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             i_clock,
   input  wire logic             i_sys_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output var  logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_chain
         always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
               stage1[g] <= RESET_VALUE[g];
               o_sync[g] <= RESET_VALUE[g];
            end else begin
               stage1[g] <= i_async[g];
               o_sync[g] <= stage1[g];
            end
         end
      end
   endgenerate
endmodule // bit_sync
`default_nettype wire

// File: hw/flash_program_erase_suspend.sv
/*
 program/erase/suspend sequencer of a serial flash, device side.
 assumes the link clock is slow enough to be sampled at 250 MHz, and
 that protection logic outside answers o_check within one cycle.
*/
// Overview of operation
// - opcode 32h, 24-bit address, data on four lanes, up to 256 bytes
// - quad program refused unless quad lane enable bit is one
// - program refused unless write latch flag is one
// - opcode 20h plus address erases a 4K sector to FFh
// - opcode 52h plus address erases a 32K block to ones
// - opcode D8h plus address erases a 64K block to ones
// - opcode C7h or 60h alone erases the whole array
// - erases ignored unless write latch flag is one
// - chip select must rise on a byte boundary, else command dropped
// - valid erase starts timed cycle, busy high throughout, low after
// - finished erase clears the write latch flag
// - sector or block erase refused on protected target
// - chip erase refused if any region is protected
// - suspend 75h taken only when not suspended and busy erasing/programming
// - suspend ignored during whole-chip erase
// - during erase suspend, erase commands rejected
// - during program suspend, program commands rejected
// - accepted suspend sets flag at once, busy drops within latency
// - other regions stay programmable/erasable while suspended
// - power-up releases suspend and clears the suspended flag
// - bytes past page end wrap to page start
// - resume 7Ah taken when suspended and idle, busy back fast
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_suspend
   import flash_seq_pkg::*;
#(
   parameter logic [TIMER_W-1:0] PROGRAM_CYCLES = TIMER_W'(PROGRAM_CYCLES_DEF),
   parameter logic [TIMER_W-1:0] SECTOR_CYCLES  = TIMER_W'(SECTOR_CYCLES_DEF),
   parameter logic [TIMER_W-1:0] BLOCK32_CYCLES = TIMER_W'(BLOCK32_CYCLES_DEF),
   parameter logic [TIMER_W-1:0] BLOCK64_CYCLES = TIMER_W'(BLOCK64_CYCLES_DEF),
   parameter logic [TIMER_W-1:0] CHIP_CYCLES    = TIMER_W'(CHIP_CYCLES_DEF),
   parameter logic [15:0]        SUSPEND_CYCLES = 16'(SUSPEND_CYCLES_DEF)
) (
   input  wire logic       i_clock,
   input  wire logic       i_sys_rst,
   input  wire logic       i_link_clk,
   input  wire logic       i_cs_n,
   input  wire logic [3:0] i_data_lanes,
   input  wire logic       i_quad_lane_enable_bit,
   input  wire logic       i_target_protected,
   input  wire logic       i_any_protected,
   output var  logic       o_busy,
   output var  logic       o_suspended_flag,
   output var  logic       o_write_latch_flag,
   output var  op_t        o_check,
   output var  logic       o_erase_valid,
   output var  op_t        o_erase,
   output var  logic       o_write_valid,
   output var  mem_write_t o_write
);
   localparam int C_RESUME_WIN = RESUME_BUSY_CYCLES;

   logic [5:0]         pins;
   logic               sclk_prev;
   logic               cs_prev;
   logic [7:0]         opcode;
   logic [3:0]         op_cnt;
   logic [15:0]        n_bits;
   logic [23:0]        addr_sr;
   logic [7:0]         byte_sr;
   logic [7:0]         page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] loaded;
   logic [7:0]         walk_idx;
   logic [TIMER_W-1:0] timer;
   logic [TIMER_W-1:0] saved_timer;
   logic [15:0]        halt_cnt;
   op_t                active;
   op_t                saved;
   seq_state_t         state;
   seq_state_t         next_state;

   // region overlap: compare at the coarser of the two granules
   function automatic logic [23:0] region_mask(input op_kind_t k);
      case (k)
         K_PROG:    region_mask = PAGE_MASK;
         K_SECTOR:  region_mask = SECTOR_MASK;
         K_BLOCK32: region_mask = BLOCK32_MASK;
         K_BLOCK64: region_mask = BLOCK64_MASK;
         default:   region_mask = CHIP_MASK;
      endcase
   endfunction

   function automatic op_kind_t kind_of(input logic [7:0] opc);
      case (opc)
         OPC_PROG, OPC_QUAD_PROG: kind_of = K_PROG;
         OPC_SECTOR:              kind_of = K_SECTOR;
         OPC_BLOCK32:             kind_of = K_BLOCK32;
         OPC_BLOCK64:             kind_of = K_BLOCK64;
         OPC_CHIP_A, OPC_CHIP_B:  kind_of = K_CHIP;
         default:                 kind_of = K_NONE;
      endcase
   endfunction

   function automatic logic [TIMER_W-1:0] duration(input op_kind_t k);
      case (k)
         K_PROG:    duration = PROGRAM_CYCLES;
         K_SECTOR:  duration = SECTOR_CYCLES;
         K_BLOCK32: duration = BLOCK32_CYCLES;
         K_BLOCK64: duration = BLOCK64_CYCLES;
         default:   duration = CHIP_CYCLES;
      endcase
   endfunction

   // pins are foreign to i_clock: {lanes, cs, link clock}
   bit_sync #(
      .WIDTH       (6),
      .RESET_VALUE (PIN_RESET)
   ) u_pin_sync (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_data_lanes, i_cs_n, i_link_clk}),
      .o_sync    (pins)
   );

   wire logic       sclk_s    = pins[0];
   wire logic       cs_s      = pins[1];
   wire logic [3:0] lanes     = pins[5:2];
   wire logic       sclk_rise = sclk_s & ~sclk_prev & ~cs_s;
   wire logic       cs_rise   = cs_s & ~cs_prev;
   wire logic       cs_fall   = ~cs_s & cs_prev;

   // edge history for the synchronised pins
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         sclk_prev <= 1'b0;
         cs_prev   <= 1'b1;
      end else begin
         sclk_prev <= sclk_s;
         cs_prev   <= cs_s;
      end
   end

   // frame decode helpers
   wire logic        op_done   = (op_cnt == 4'(OPCODE_BITS));
   wire logic        quad      = op_done && (opcode == OPC_QUAD_PROG);
   wire logic [15:0] step      = quad ? 16'h0004 : 16'h0001;
   wire logic [15:0] data_bits = n_bits - ADDR_BITS;
   wire logic [7:0]  buf_idx   = addr_sr[7:0] + data_bits[10:3];
   wire logic [7:0]  next_byte = quad ? {byte_sr[3:0], lanes} : {byte_sr[6:0], lanes[0]};
   wire logic        byte_end  = quad ? (n_bits[2:0] == 3'h4) : (n_bits[2:0] == 3'h7);
   wire op_kind_t    fkind     = kind_of(opcode);
   wire logic        bare      = op_done && (n_bits == 16'h0000);
   wire logic        addr_only = op_done && (n_bits == ADDR_BITS);
   wire logic        prog_len  = op_done && (n_bits >= MIN_PROG) && (n_bits[2:0] == 3'h0);

   wire logic sus_prog  = o_suspended_flag && (saved.kind == K_PROG);
   wire logic sus_erase = o_suspended_flag && (saved.kind != K_PROG);
   // page buffer is frozen while busy or while a suspended program owns it
   wire logic buf_ok    = !o_busy && !sus_prog;

   // opcode, address and data shifting on link clock rises
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || cs_fall) begin
         op_cnt <= 4'h0;
         n_bits <= 16'h0000;
         opcode <= 8'h00;
         addr_sr <= 24'h000000;
         byte_sr <= 8'h00;
      end else if (sclk_rise) begin
         if (!op_done) begin
            opcode <= {opcode[6:0], lanes[0]};
            op_cnt <= op_cnt + 4'h1;
         end else begin
            if (n_bits < BITS_SAT) begin
               n_bits <= n_bits + step;
            end
            if (n_bits < ADDR_BITS) begin
               addr_sr <= quad ? {addr_sr[19:0], lanes} : {addr_sr[22:0], lanes[0]};
            end else begin
               byte_sr <= next_byte;
            end
         end
      end
   end

   // page buffer; index wraps inside the page
   always_ff @(posedge i_clock) begin
      if (sclk_rise && op_done && kind_of(opcode) == K_PROG && n_bits >= ADDR_BITS && byte_end && buf_ok) begin
         page_buf[buf_idx] <= next_byte;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         loaded <= '0;
      end else if (cs_fall && buf_ok) begin
         loaded <= '0;
      end else if (sclk_rise && op_done && fkind == K_PROG && n_bits >= ADDR_BITS && byte_end && buf_ok) begin
         loaded[buf_idx] <= 1'b1;
      end
   end

   // target offered to the protection logic outside
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_check <= '{kind: K_NONE, addr: 24'h000000};
      end else begin
         o_check <= '{kind: fkind, addr: addr_sr};
      end
   end

   // acceptance of commands at the rise of chip select
   wire logic clash = o_suspended_flag &&
      ((addr_sr & ~(region_mask(fkind) | region_mask(saved.kind))) ==
       (saved.addr & ~(region_mask(fkind) | region_mask(saved.kind))));
   wire logic can_write = cs_rise && !o_busy && o_write_latch_flag && !clash;
   wire logic start_prog = can_write && prog_len && fkind == K_PROG && !sus_prog && !i_target_protected &&
      (opcode != OPC_QUAD_PROG || i_quad_lane_enable_bit);
   wire logic block_ok = (fkind == K_SECTOR || fkind == K_BLOCK32 || fkind == K_BLOCK64) &&
      addr_only && !i_target_protected;
   wire logic chip_ok = fkind == K_CHIP && bare && !i_any_protected;
   wire logic start_erase = can_write && !sus_erase && (block_ok || chip_ok);
   wire logic start_op = start_prog || start_erase;
   wire logic suspend_ok = cs_rise && bare && opcode == OPC_SUSPEND && state == ST_RUN &&
      !o_suspended_flag && active.kind != K_CHIP;
   wire logic resume_ok = cs_rise && bare && opcode == OPC_RESUME && o_suspended_flag && !o_busy;
   wire logic latch_set = cs_rise && bare && opcode == OPC_WRITE_EN && !o_busy;
   wire logic latch_clr = cs_rise && bare && opcode == OPC_WRITE_DIS && !o_busy;
   wire logic run_end = state == ST_RUN && timer <= TIMER_W'(1) && !suspend_ok;

   // sequencer next state; anything rejected leaves the state alone
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (start_op) begin
               next_state = ST_RUN;
            end else if (resume_ok) begin
               next_state = ST_RESUME;
            end
         end
         ST_RUN: begin
            if (suspend_ok) begin
               next_state = ST_HALT;
            end else if (run_end) begin
               next_state = (active.kind == K_PROG) ? ST_FLUSH : ST_IDLE;
            end
         end
         ST_HALT: begin
            if (halt_cnt <= 16'h0001) begin
               next_state = ST_IDLE;
            end
         end
         ST_FLUSH: begin
            if (walk_idx == 8'hff) begin
               next_state = ST_IDLE;
            end
         end
         ST_RESUME: next_state = ST_RUN;
         default:   next_state = ST_IDLE;
      endcase
   end

   // state and busy; busy is registered from the next state so it changes in the same cycle as the state
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state  <= ST_IDLE;
         o_busy <= 1'b0;
      end else begin
         state  <= next_state;
         o_busy <= (next_state != ST_IDLE);
      end
   end

   // active and saved contexts with their cycle timers
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         active      <= '{kind: K_NONE, addr: 24'h000000};
         saved       <= '{kind: K_NONE, addr: 24'h000000};
         timer       <= '0;
         saved_timer <= '0;
         halt_cnt    <= 16'h0000;
      end else begin
         if (state == ST_IDLE && start_op) begin
            active <= '{kind: fkind, addr: addr_sr};
            timer  <= duration(fkind);
         end else if (state == ST_RESUME) begin
            active <= saved;
            timer  <= saved_timer;
         end else if (state == ST_RUN && !suspend_ok && timer != '0) begin
            timer <= timer - TIMER_W'(1);
         end
         if (suspend_ok) begin
            halt_cnt <= SUSPEND_CYCLES;
         end else if (state == ST_HALT) begin
            halt_cnt <= halt_cnt - 16'h0001;
         end
         if (state == ST_HALT && next_state == ST_IDLE) begin
            saved       <= active;
            saved_timer <= timer;
         end
      end
   end

   // suspended flag; a power-up reset always releases it
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_suspended_flag <= 1'b0;
      end else if (suspend_ok) begin
         o_suspended_flag <= 1'b1;
      end else if (resume_ok) begin
         o_suspended_flag <= 1'b0;
      end
   end

   // write latch: set/clear only while idle, completion only while busy
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_write_latch_flag <= 1'b0;
      end else if ((run_end && active.kind != K_PROG) || (state == ST_FLUSH && next_state == ST_IDLE)) begin
         o_write_latch_flag <= 1'b0;
      end else if (latch_set) begin
         o_write_latch_flag <= 1'b1;
      end else if (latch_clr) begin
         o_write_latch_flag <= 1'b0;
      end
   end

   // erase command to the array at the end of the timed cycle
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_erase_valid <= 1'b0;
         o_erase       <= '{kind: K_NONE, addr: 24'h000000};
      end else begin
         o_erase_valid <= run_end && active.kind != K_PROG;
         o_erase       <= active;
      end
   end

   // program flush walks the page, one byte a cycle, loaded bytes only
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         walk_idx      <= 8'h00;
         o_write_valid <= 1'b0;
         o_write       <= '{addr: 24'h000000, data: 8'h00};
      end else begin
         walk_idx      <= (state == ST_FLUSH) ? walk_idx + 8'h01 : 8'h00;
         o_write_valid <= (state == ST_FLUSH) && loaded[walk_idx];
         o_write       <= '{addr: {active.addr[23:8], walk_idx}, data: page_buf[walk_idx]};
      end
   end

   // checks
   sequence s_resume_back;
      ##1 !o_suspended_flag ##[0:C_RESUME_WIN] o_busy;
   endsequence

   property p_suspend_flag;
      @(posedge i_clock) disable iff (i_sys_rst) suspend_ok |=> o_suspended_flag && o_busy;
   endproperty
   a_suspend_flag: assert property (p_suspend_flag) else $error("suspend flag not set");

   property p_halt_bound;
      @(posedge i_clock) disable iff (i_sys_rst) state == ST_HALT |-> halt_cnt <= SUSPEND_CYCLES && o_busy;
   endproperty
   a_halt_bound: assert property (p_halt_bound) else $error("suspend latency exceeded");

   property p_resume;
      @(posedge i_clock) disable iff (i_sys_rst) resume_ok |-> s_resume_back;
   endproperty
   a_resume: assert property (p_resume) else $error("resume did not restore busy");

   property p_erase_clears_latch;
      @(posedge i_clock) disable iff (i_sys_rst) o_erase_valid |-> !o_write_latch_flag && !o_busy;
   endproperty
   a_erase_clears_latch: assert property (p_erase_clears_latch) else $error("latch after erase");

   property p_no_chip_suspend;
      @(posedge i_clock) disable iff (i_sys_rst) $rose(o_suspended_flag) |-> $past(active.kind) != K_CHIP;
   endproperty
   a_no_chip_suspend: assert property (p_no_chip_suspend) else $error("chip erase suspended");

   property p_quad_enable;
      @(posedge i_clock) disable iff (i_sys_rst) start_prog && opcode == OPC_QUAD_PROG |-> i_quad_lane_enable_bit;
   endproperty
   a_quad_enable: assert property (p_quad_enable) else $error("quad program without enable");

   property p_latch_needed;
      @(posedge i_clock) disable iff (i_sys_rst) $rose(o_busy) && !$past(resume_ok, 2) |-> $past(o_write_latch_flag);
   endproperty
   a_latch_needed: assert property (p_latch_needed) else $error("operation without latch");

   property p_erase_in_suspend;
      @(posedge i_clock) disable iff (i_sys_rst) sus_erase |-> !start_erase;
   endproperty
   a_erase_in_suspend: assert property (p_erase_in_suspend) else $error("erase during erase suspend");

   property p_reject_quiet;
      @(posedge i_clock) disable iff (i_sys_rst)
         state == ST_IDLE && !start_op && !resume_ok |=> !o_busy && $stable(o_suspended_flag);
   endproperty
   a_reject_quiet: assert property (p_reject_quiet) else $error("rejected command changed status");
endmodule // flash_program_erase_suspend
`default_nettype wire

// File: bench/flash_host_model.sv
/*
 host model: shifts command frames into the sequencer.
 assumes a 4 ns i_clock; link clock 32 ns, low and still between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
   import flash_seq_pkg::*;
(
   input  wire logic       i_clock,
   output var  logic       o_link_clk,
   output var  logic       o_cs_n,
   output var  logic [3:0] o_data_lanes
);
   initial begin
      o_link_clk   = 1'b0;
      o_cs_n       = 1'b1;
      o_data_lanes = 4'h5;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // one frame; cut drops trailing link clocks so cs rises off a byte boundary
   task automatic frame(input logic [7:0] op, input int abits, input logic [23:0] a,
                        input int nb, input logic [7:0] d0, input int cut);
      logic [3:0] q[$];
      logic [7:0] b;
      for (int i = 7; i >= 0; i--) q.push_back({3'h0, op[i]});
      if (op == OPC_QUAD_PROG) begin
         for (int i = 5; i >= 0; i--) q.push_back(a[i*4+:4]);
         for (int n = 0; n < nb; n++) begin
            b = d0 + 8'(n);
            q.push_back(b[7:4]);
            q.push_back(b[3:0]);
         end
      end else begin
         for (int i = abits - 1; i >= 0; i--) q.push_back({3'h0, a[i]});
      end
      repeat (cut) void'(q.pop_back());
      tick(1);
      o_cs_n <= 1'b0;
      foreach (q[i]) begin
         o_data_lanes <= q[i];
         tick(4);
         o_link_clk <= 1'b1;
         tick(4);
         o_link_clk <= 1'b0;
      end
      tick(4);
      o_cs_n       <= 1'b1;
      o_data_lanes <= ~o_data_lanes; // released lanes must not keep the last value
      tick(8);
   endtask
endmodule // flash_host_model
`default_nettype wire

// File: bench/tb.sv
/*
 self-checking bench of the program/erase/suspend sequencer.
 assumes flash_host_model as the host and shortened cycle counts.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import flash_seq_pkg::*;
();
   logic       i_clock = 1'b0;
   logic       i_sys_rst, qe, tprot, aprot, busy, susp, write_latch_flag, lclk, cs_n, ev, wv;
   logic [3:0] lanes;
   op_t        eo, ee, eq[$];
   mem_write_t wo, we, wq[$];
   int         miscompares = 0, cmp_count = 0, cycles = 0;
   logic [7:0] eop[5] = '{OPC_SECTOR, OPC_BLOCK32, OPC_BLOCK64, OPC_CHIP_A, OPC_CHIP_B};
   op_kind_t   ekd[5] = '{K_SECTOR, K_BLOCK32, K_BLOCK64, K_CHIP, K_CHIP};
   logic [7:0] rop[5] = '{OPC_QUAD_PROG, OPC_SECTOR, OPC_CHIP_B, OPC_SECTOR, OPC_QUAD_PROG};
   always #2 i_clock = ~i_clock;
   flash_host_model host_u (.i_clock(i_clock), .o_link_clk(lclk), .o_cs_n(cs_n), .o_data_lanes(lanes));
   flash_program_erase_suspend #(.PROGRAM_CYCLES(40'h12c), .SECTOR_CYCLES(40'h190), .BLOCK32_CYCLES(40'h1c2),
      .BLOCK64_CYCLES(40'h1f4), .CHIP_CYCLES(40'h226)) dut_u (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_link_clk(lclk), .i_cs_n(cs_n), .i_data_lanes(lanes), .i_quad_lane_enable_bit(qe),
      .i_target_protected(tprot), .i_any_protected(aprot), .o_busy(busy), .o_suspended_flag(susp),
      .o_write_latch_flag(write_latch_flag), .o_check(), .o_erase_valid(ev), .o_erase(eo), .o_write_valid(wv), .o_write(wo));
   task automatic tally_and_finish();
      $display("compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // flags as {busy, suspended, latch}, read after the edge has settled
   task automatic flags(input logic [2:0] e);
      #1 chk({busy, susp, write_latch_flag}, e);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge i_clock);
      flags(3'b000);
   endtask
   task automatic fr(input logic [7:0] op, input logic [23:0] a, input int nb, input int cut);
      host_u.frame(op, (op inside {OPC_SECTOR, OPC_BLOCK32, OPC_BLOCK64}) ? 24 : 0, a, nb, 8'h00, cut);
   endtask
   task automatic erase(input logic [7:0] op, input op_kind_t k);
      ee = {k, 24'($urandom)};
      fr(OPC_WRITE_EN, 0, 0, 0);
      eq.push_back(ee);
      fr(op, ee.addr, 0, 0);
      flags(3'b101);
   endtask
   // expected bytes: later data overwrites a wrapped index, pulses in index order
   task automatic prog(input logic [23:0] a, input int nb);
      logic [7:0] d0, img[256];
      bit         hit[256];
      d0 = 8'($urandom);
      for (int n = 0; n < nb; n++) begin
         img[8'(a[7:0] + n)] = d0 + 8'(n);
         hit[8'(a[7:0] + n)] = 1'b1;
      end
      for (int i = 0; i < 256; i++) if (hit[i]) wq.push_back({a[23:8], 8'(i), img[i]});
      fr(OPC_WRITE_EN, 0, 0, 0);
      host_u.frame(OPC_QUAD_PROG, 0, a, nb, d0, 0);
   endtask
   // scoreboard and run limit
   always @(posedge i_clock) begin
      cycles++;
      if (ev === 1'b1) begin
         ee = (eq.size() != 0) ? eq.pop_front() : '1;
         if (ee.kind == K_CHIP) ee.addr = eo.addr;
         chk(eo, ee);
      end
      if (wv === 1'b1) begin
         we = (wq.size() != 0) ? wq.pop_front() : '1;
         chk(wo, we);
      end
      if (cycles == 60000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      i_sys_rst = 1'b1;
      qe = 1'b0;
      tprot = 1'b0;
      aprot = 1'b0;
      void'($urandom(32'h8a6e68e7));
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_clock);
      flags(3'b000);
      fr(OPC_SECTOR, 24'h001000, 0, 0);
      flags(3'b000);
      fr(OPC_WRITE_EN, 0, 0, 0);
      for (int i = 0; i < 5; i++) begin
         qe <= (i != 0);
         tprot <= (i == 1);
         aprot <= (i == 2);
         fr(rop[i], 24'h012345, 2, (i > 2) ? 1 : 0);
         flags(3'b001);
      end
      aprot <= 1'b0;
      fr(OPC_WRITE_DIS, 0, 0, 0);
      fr(OPC_QUAD_PROG, 24'h000000, 2, 0);
      flags(3'b000);
      $display("refusal test done");
      for (int i = 0; i < 5; i++) begin
         erase(eop[i], ekd[i]);
         wait_idle();
      end
      $display("erase test done");
      erase(OPC_BLOCK32, K_BLOCK32);
      fr(OPC_SUSPEND, 0, 0, 0);
      flags(3'b111);
      // suspend latency runs at its default length, so busy must be down after it
      repeat (int'(SUSPEND_CYCLES_DEF) + 2) @(posedge i_clock);
      flags(3'b011);
      fr(OPC_SECTOR, 24'($urandom), 0, 0);
      fr(OPC_SUSPEND, 0, 0, 0);
      flags(3'b011);
      fr(OPC_RESUME, 0, 0, 0);
      flags(3'b101);
      wait_idle();
      erase(OPC_CHIP_A, K_CHIP);
      fr(OPC_SUSPEND, 0, 0, 0);
      flags(3'b101);
      wait_idle();
      $display("suspend test done");
      prog(24'($urandom), 258);
      wait_idle();
      fr(OPC_WRITE_EN, 0, 0, 0);
      fr(OPC_QUAD_PROG, 24'h000100, 1, 0);
      fr(OPC_SUSPEND, 0, 0, 0);
      repeat (int'(SUSPEND_CYCLES_DEF) + 2) @(posedge i_clock);
      fr(OPC_QUAD_PROG, 24'h040000, 1, 0);
      flags(3'b011);
      @(posedge i_clock);
      i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      repeat (3) @(posedge i_clock);
      flags(3'b000);
      $display("program test done");
      chk(eq.size() + wq.size(), 0);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
